// *** core/canfd_dma_tdc_defines.svh ***
// constants for the dma trigger, delay compensation and mode timing block
// assumes one channel; included by bare name, definitions only
`ifndef CANFD_DMA_TDC_DEFINES_SVH
`define CANFD_DMA_TDC_DEFINES_SVH

// ------------------------------
// dma sources and targets
// ------------------------------
`define RX_SRC_NUM        9
`define TX_TGT_NUM        3
`define TX_TRX            0
`define TX_TX_QUEUE_ZERO           1
`define TX_TX_QUEUE_THREE           2
`define TXQ_PAYLOAD_WORDS 5'd16

// ------------------------------
// delay compensation
// ------------------------------
`define TDC_MAX_BITS      15'd6
`define SSP_OFFSET_PLUS   16'd1
`define RX_SYNC_LAT       15'd2
`define RESULT_MAX        15'd255

// ------------------------------
// mode transition limits (core_clk cycles, nominal bits or frames)
// ------------------------------
`define GLB_STOP_RST_CLK    4'd3
`define GLB_RST_RUN_CLK     4'd10
`define GLB_TEST_RUN_CLK    4'd3
`define GLB_TO_RST_BITS     4'd2
`define GLB_RUN_TEST_FRAMES 4'd3
`define CH_STOP_RST_CLK     4'd3
`define CH_RST_HALT_BITS    4'd3
`define CH_TO_COMM_BITS     4'd4
`define CH_HALT_RST_BITS    4'd2
`define CH_COMM_RST_BITS    4'd3
`define CH_COMM_HALT_FRAMES 4'd2
`define MODE_AFTER_RESET    2'h3

`endif

// *** core/canfd_dma_tdc_mode_timing.sv ***
// dma triggers, transmitter delay compensation and mode timing, one channel
// assumes fifo status and dma strobes on core_clk; can_rx is an async pin
//
// How it works
// - Dma request per rx fifo, trx fifo and tx queues 0, 3.
// - Rx request: dma enabled and unread message present.
// - Trx fifo pointer advances after a full payload.
// - Tx queue pointer advances after 64 bytes; dma pads.
// - Dma active status holds until transfer end.
// - Storage continues while dma is off.
// - Compensation only when enabled; offset and select set ssp.
// - Select 0: ssp is delay plus offset, rounded to tq.
// - Select 1: ssp from offset, rounded when prescaler nonzero.
// - Offset-only ssp is offset plus one.
// - Loop delays up to six data bits handled.
// - Result in clocks from fdf/res edge to can_rx fall, updated at the fall with select 0.
// - Violation flag sets beyond six data bits.
// - Global stop/reset 3 clocks, reset to test/run 10, test to run 3.
// - Global to reset within 2 bits, run to test within 3 frames.
// - Channel transitions meet clock, bit or frame limits.
// - Error interrupt on violation flag with its enable.
`timescale 1ns/1ns
`default_nettype none
`include "canfd_dma_tdc_defines.svh"

module canfd_dma_tdc_mode_timing
   import canfd_dma_tdc_pkg::*;
(
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   // receive dma
   input  wire rx_dma_enable_s         rx_dma_enable_reg,
   input  wire logic [`RX_SRC_NUM-1:0] rx_unread,
   input  wire logic [`RX_SRC_NUM-1:0] rx_dma_ack,
   input  wire logic [`RX_SRC_NUM-1:0] rx_dma_done,
   output logic [`RX_SRC_NUM-1:0]      rx_dma_req,
   // receive storage
   input  wire logic [`RX_SRC_NUM-1:0] rx_fifo_on,
   input  wire logic [`RX_SRC_NUM-1:0] rx_msg_arrive,
   output logic [`RX_SRC_NUM-1:0]      rx_store_strobe,
   // transmit dma
   input  wire tx_dma_enable_s         tx_dma_enable_reg,
   input  wire logic [2:0]             trxfifo_payload_size,
   input  wire logic [`TX_TGT_NUM-1:0] tx_space,
   input  wire logic [`TX_TGT_NUM-1:0] tx_word_wr,
   input  wire logic [`TX_TGT_NUM-1:0] tx_dma_done,
   output logic [`TX_TGT_NUM-1:0]      tx_dma_req,
   output logic [`TX_TGT_NUM-1:0]      tx_ptr_advance,
   output dma_status_s                 dma_status_reg,
   // delay compensation
   input  wire fd_config_s             fd_config_reg,
   input  wire logic [7:0]             data_prescaler,
   input  wire logic [11:0]            data_bit_clocks,
   input  wire logic                   fdf_res_edge,
   input  wire logic                   can_rx,
   input  wire logic                   violation_clear,
   input  wire logic                   delay_comp_violation_irq_en,
   output logic [15:0]                 secondary_sample_point,
   output logic [7:0]                  delay_comp_result,
   output logic                        delay_comp_violation,
   output logic                        channel_error_irq,
   // mode control
   input  wire logic [15:0]            nominal_bit_clocks,
   input  wire logic                   frame_end,
   input  wire logic                   bus_idle,
   input  wire mode_e                  global_mode_req,
   input  wire logic                   global_req_valid,
   input  wire mode_e                  channel_mode_req,
   input  wire logic                   channel_req_valid,
   output mode_e                       global_mode,
   output logic                        global_busy,
   output mode_e                       channel_mode,
   output logic                        channel_busy
);

   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [4:0] payload_words(input logic [2:0] size);
      unique case (size)
         3'h0: payload_words = 5'd2;
         3'h1: payload_words = 5'd3;
         3'h2: payload_words = 5'd4;
         3'h3: payload_words = 5'd5;
         3'h4: payload_words = 5'd6;
         3'h5: payload_words = 5'd8;
         3'h6: payload_words = 5'd12;
         3'h7: payload_words = 5'd16;
      endcase
   endfunction

   // round to the nearest multiple of one time quantum
   function automatic logic [15:0] round_tq(input logic [15:0] x,
                                            input logic [7:0]  presc);
      logic [15:0] tq;
      tq       = {8'h00, presc} + 16'd1;
      round_tq = ((x + (tq >> 1)) / tq) * tq;
   endfunction

   // ------------------------------
   // dma request and progress tracking
   // ------------------------------
   logic [`RX_SRC_NUM-1:0]   rx_req_next;
   logic [`RX_SRC_NUM-1:0]   store_next;
   logic [`TX_TGT_NUM-1:0]   tx_en;
   logic [`TX_TGT_NUM-1:0]   tx_req_next;
   logic [`TX_TGT_NUM-1:0]   adv_next;
   dma_status_s              status_next;
   logic [`TX_TGT_NUM-1:0][4:0] word_cnt_reg;
   logic [`TX_TGT_NUM-1:0][4:0] word_cnt_next;
   logic [4:0]               target_words;

   always_comb begin
      rx_req_next = rx_dma_enable_reg & rx_unread;
      store_next  = rx_msg_arrive & rx_fifo_on;
      tx_en       = {tx_dma_enable_reg.txq_three_dma_enable,
                     tx_dma_enable_reg.txq_zero_dma_enable,
                     tx_dma_enable_reg.trxfifo_dma_enable};
      tx_req_next = tx_en & tx_space;
      // a new access wins over transfer end in the same cycle
      status_next.rxfifo_dma_active  = rx_dma_ack[7:0] |
         (dma_status_reg.rxfifo_dma_active & ~rx_dma_done[7:0]);
      status_next.trxfifo_dma_active = rx_dma_ack[8] |
         (dma_status_reg.trxfifo_dma_active & ~rx_dma_done[8]);
      status_next.tx_active = tx_word_wr |
         (dma_status_reg.tx_active & ~tx_dma_done);
      for (int i = 0; i < `TX_TGT_NUM; i++) begin
         target_words = (i == `TX_TRX) ? payload_words(trxfifo_payload_size)
                                       : `TXQ_PAYLOAD_WORDS;
         adv_next[i]      = tx_word_wr[i] &&
                            (word_cnt_reg[i] + 5'd1 == target_words);
         word_cnt_next[i] = adv_next[i]   ? 5'd0 :
                            tx_word_wr[i] ? word_cnt_reg[i] + 5'd1 :
                                            word_cnt_reg[i];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_dma_req      <= '0;
         rx_store_strobe <= '0;
         tx_dma_req      <= '0;
         tx_ptr_advance  <= '0;
         dma_status_reg  <= '0;
         word_cnt_reg    <= '0;
      end else begin
         rx_dma_req      <= rx_req_next;
         rx_store_strobe <= store_next;
         tx_dma_req      <= tx_req_next;
         tx_ptr_advance  <= adv_next;
         dma_status_reg  <= status_next;
         word_cnt_reg    <= word_cnt_next;
      end
   end

   // ------------------------------
   // can_rx synchroniser
   // ------------------------------
   logic rx_s1_reg;
   logic rx_s2_reg;
   logic rx_s3_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         rx_s3_reg <= 1'b1;
      end else begin
         rx_s1_reg <= can_rx;
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
      end
   end

   // ------------------------------
   // delay measurement and secondary sample point
   // ------------------------------
   logic        meas_on_reg;
   logic        meas_on_next;
   logic [14:0] meas_cnt_reg;
   logic [14:0] meas_cnt_next;
   logic [14:0] delay_reg;
   logic [14:0] delay_next;
   logic [7:0]  result_next;
   logic        viol_next;
   logic        irq_next;
   logic [15:0] ssp_next;
   logic [14:0] max_delay;
   logic [14:0] seen_delay;
   logic        rx_fall;
   logic        measuring_mode;

   always_comb begin
      measuring_mode = fd_config_reg.delay_comp_enable &&
                       !fd_config_reg.offset_only_select;
      rx_fall      = rx_s3_reg && !rx_s2_reg;
      // sync latency is taken back out of the raw count
      seen_delay   = (meas_cnt_reg > `RX_SYNC_LAT) ? meas_cnt_reg - `RX_SYNC_LAT : 15'd0;
      max_delay    = `TDC_MAX_BITS * {3'h0, data_bit_clocks};
      meas_on_next = meas_on_reg;
      meas_cnt_next = meas_cnt_reg;
      delay_next   = delay_reg;
      result_next  = delay_comp_result;
      viol_next    = delay_comp_violation;
      if (violation_clear) begin
         viol_next = 1'b0;
      end
      if (fdf_res_edge && measuring_mode) begin
         meas_on_next  = 1'b1;
         meas_cnt_next = 15'd0;
      end else if (meas_on_reg) begin
         if (rx_fall) begin
            meas_on_next = 1'b0;
            delay_next   = seen_delay;
            result_next  = (seen_delay > `RESULT_MAX) ? 8'hff : seen_delay[7:0];
         end else if (seen_delay > max_delay) begin
            meas_on_next = 1'b0;
            viol_next    = 1'b1;
         end else begin
            meas_cnt_next = meas_cnt_reg + 15'd1;
         end
      end
      if (!fd_config_reg.delay_comp_enable) begin
         ssp_next = 16'd0;
      end else if (fd_config_reg.offset_only_select) begin
         ssp_next = {8'h00, fd_config_reg.ssp_offset} + `SSP_OFFSET_PLUS;
         if (data_prescaler != 8'h00) begin
            ssp_next = round_tq(ssp_next, data_prescaler);
         end
      end else begin
         ssp_next = round_tq({1'b0, delay_reg} + {8'h00, fd_config_reg.ssp_offset},
                             data_prescaler);
      end
      irq_next = viol_next && delay_comp_violation_irq_en;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meas_on_reg            <= 1'b0;
         meas_cnt_reg           <= 15'd0;
         delay_reg              <= 15'd0;
         delay_comp_result      <= 8'h00;
         delay_comp_violation   <= 1'b0;
         channel_error_irq      <= 1'b0;
         secondary_sample_point <= 16'd0;
      end else begin
         meas_on_reg            <= meas_on_next;
         meas_cnt_reg           <= meas_cnt_next;
         delay_reg              <= delay_next;
         delay_comp_result      <= result_next;
         delay_comp_violation   <= viol_next;
         channel_error_irq      <= irq_next;
         secondary_sample_point <= ssp_next;
      end
   end

   // ------------------------------
   // nominal bit tick
   // ------------------------------
   // single channel, so it is also the slowest one for global limits
   logic [15:0] bit_cnt_reg;
   logic [15:0] bit_cnt_next;
   logic        bit_tick_reg;
   logic        bit_tick_next;

   always_comb begin
      bit_tick_next = (bit_cnt_reg + 16'd1 >= nominal_bit_clocks);
      bit_cnt_next  = bit_tick_next ? 16'd0 : bit_cnt_reg + 16'd1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bit_cnt_reg  <= 16'd0;
         bit_tick_reg <= 1'b0;
      end else begin
         bit_cnt_reg  <= bit_cnt_next;
         bit_tick_reg <= bit_tick_next;
      end
   end

   // ------------------------------
   // mode sequencers
   // ------------------------------
   mode_sequencer #(.IS_GLOBAL(1'b1)) global_seq (
      .core_clk  (core_clk),
      .rst       (rst),
      .mode_req  (global_mode_req),
      .req_valid (global_req_valid),
      .bit_tick  (bit_tick_reg),
      .frame_end (frame_end),
      .bus_idle  (bus_idle),
      .mode_now  (global_mode),
      .busy      (global_busy)
   );

   mode_sequencer #(.IS_GLOBAL(1'b0)) channel_seq (
      .core_clk  (core_clk),
      .rst       (rst),
      .mode_req  (channel_mode_req),
      .req_valid (channel_req_valid),
      .bit_tick  (bit_tick_reg),
      .frame_end (frame_end),
      .bus_idle  (bus_idle),
      .mode_now  (channel_mode),
      .busy      (channel_busy)
   );

endmodule // canfd_dma_tdc_mode_timing
`default_nettype wire

// *** core/canfd_dma_tdc_pkg.sv ***
// types shared by the dma trigger / delay compensation block
// assumes the defines header for all numeric constants
package canfd_dma_tdc_pkg;

   // run = operation/communication, hold = test/halt
   typedef enum logic [1:0] {
      MODE_RUN   = 2'h0,
      MODE_RESET = 2'h1,
      MODE_HOLD  = 2'h2,
      MODE_STOP  = 2'h3
   } mode_e;

   typedef enum logic [1:0] {
      UNIT_CLK   = 2'h0,
      UNIT_BIT   = 2'h1,
      UNIT_FRAME = 2'h2
   } wait_unit_e;

   typedef struct packed {
      logic       legal;
      wait_unit_e unit;
      logic [3:0] limit;
   } wait_s;

   typedef struct packed {
      logic       trxfifo_dma_enable;
      logic [7:0] rxfifo_dma_enable;
   } rx_dma_enable_s;

   typedef struct packed {
      logic txq_three_dma_enable;
      logic txq_zero_dma_enable;
      logic trxfifo_dma_enable;
   } tx_dma_enable_s;

   typedef struct packed {
      logic [2:0] tx_active;
      logic       trxfifo_dma_active;
      logic [7:0] rxfifo_dma_active;
   } dma_status_s;

   typedef struct packed {
      logic       delay_comp_enable;
      logic       offset_only_select;
      logic [7:0] ssp_offset;
   } fd_config_s;

endpackage

// *** core/mode_sequencer.sv ***
// global or channel mode sequencer with bounded transition times
// assumes bit_tick and frame_end are one-cycle pulses on core_clk
`timescale 1ns/1ns
`default_nettype none
`include "canfd_dma_tdc_defines.svh"

module mode_sequencer
   import canfd_dma_tdc_pkg::*;
#(
   parameter bit IS_GLOBAL = 1'b0
) (
   // clock and reset
   input  wire logic  core_clk,
   input  wire logic  rst,
   // mode request
   input  wire mode_e mode_req,
   input  wire logic  req_valid,
   // time bases
   input  wire logic  bit_tick,
   input  wire logic  frame_end,
   input  wire logic  bus_idle,
   // status
   output mode_e      mode_now,
   output logic       busy
);

   // ------------------------------
   // transition table
   // ------------------------------
   function automatic wait_s lookup(input mode_e from, input mode_e to);
      wait_s w;
      w = '{legal: 1'b1, unit: UNIT_CLK, limit: 4'd2};
      if (from == to) begin
         w.legal = 1'b0;
      end else if ((from == MODE_STOP) != (to == MODE_STOP)) begin
         if (from == MODE_RESET || to == MODE_RESET) begin
            w.limit = IS_GLOBAL ? `GLB_STOP_RST_CLK : `CH_STOP_RST_CLK;
         end else begin
            w.legal = 1'b0;
         end
      end else if (from == MODE_RESET) begin
         w.unit  = IS_GLOBAL ? UNIT_CLK : UNIT_BIT;
         w.limit = IS_GLOBAL ? `GLB_RST_RUN_CLK :
                   (to == MODE_HOLD ? `CH_RST_HALT_BITS : `CH_TO_COMM_BITS);
      end else if (to == MODE_RESET) begin
         w.unit  = UNIT_BIT;
         w.limit = IS_GLOBAL ? `GLB_TO_RST_BITS :
                   (from == MODE_HOLD ? `CH_HALT_RST_BITS : `CH_COMM_RST_BITS);
      end else if (to == MODE_RUN) begin
         w.unit  = IS_GLOBAL ? UNIT_CLK : UNIT_BIT;
         w.limit = IS_GLOBAL ? `GLB_TEST_RUN_CLK : `CH_TO_COMM_BITS;
      end else begin
         w.unit  = UNIT_FRAME;
         w.limit = IS_GLOBAL ? `GLB_RUN_TEST_FRAMES : `CH_COMM_HALT_FRAMES;
      end
      return w;
   endfunction

   // ------------------------------
   // sequencer state
   // ------------------------------
   mode_e      target_reg;
   mode_e      target_next;
   mode_e      mode_next;
   wait_unit_e unit_reg;
   wait_unit_e unit_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic       busy_next;
   wait_s      w;
   logic       event_hit;

   // counting limit-1 events keeps us inside the limit: first bit
   // tick or frame end can come as late as one unit after the request
   always_comb begin
      w           = lookup(mode_now, mode_req);
      target_next = target_reg;
      unit_next   = unit_reg;
      cnt_next    = cnt_reg;
      busy_next   = busy;
      mode_next   = mode_now;
      unique case (unit_reg)
         UNIT_CLK:   event_hit = 1'b1;
         UNIT_BIT:   event_hit = bit_tick;
         UNIT_FRAME: event_hit = frame_end;
         default:    event_hit = 1'b1;
      endcase
      if (!busy) begin
         if (req_valid && w.legal) begin
            target_next = mode_req;
            unit_next   = w.unit;
            cnt_next    = w.limit - 4'd1;
            busy_next   = 1'b1;
         end
      end else if ((unit_reg == UNIT_FRAME && bus_idle) ||
                   (event_hit && cnt_reg == 4'd1)) begin
         mode_next = target_reg;
         busy_next = 1'b0;
      end else if (event_hit) begin
         cnt_next = cnt_reg - 4'd1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         target_reg <= mode_e'(`MODE_AFTER_RESET);
         unit_reg   <= UNIT_CLK;
         cnt_reg    <= 4'd0;
         busy       <= 1'b0;
         mode_now   <= mode_e'(`MODE_AFTER_RESET);
      end else begin
         target_reg <= target_next;
         unit_reg   <= unit_next;
         cnt_reg    <= cnt_next;
         busy       <= busy_next;
         mode_now   <= mode_next;
      end
   end

endmodule // mode_sequencer
`default_nettype wire

// *** sim/canfd_dma_tdc_mode_timing_asserts.sv ***
// checker for the dma trigger and delay compensation ports
// assumes it is bound onto canfd_dma_tdc_mode_timing
`timescale 1ns/1ns
`default_nettype none
module canfd_dma_tdc_mode_timing_asserts
   import canfd_dma_tdc_pkg::*;
(
   // clock and reset
   input wire logic           core_clk,
   input wire logic           rst,
   // dma
   input wire rx_dma_enable_s rx_dma_enable_reg,
   input wire logic [8:0]     rx_unread,
   input wire logic [8:0]     rx_dma_ack,
   input wire logic [8:0]     rx_dma_done,
   input wire logic [8:0]     rx_dma_req,
   input wire logic [8:0]     rx_fifo_on,
   input wire logic [8:0]     rx_msg_arrive,
   input wire logic [8:0]     rx_store_strobe,
   input wire tx_dma_enable_s tx_dma_enable_reg,
   input wire logic [2:0]     tx_space,
   input wire logic [2:0]     tx_dma_req,
   input wire logic [2:0]     tx_ptr_advance,
   input wire dma_status_s    dma_status_reg,
   // compensation
   input wire fd_config_s     fd_config_reg,
   input wire logic           violation_clear,
   input wire logic           delay_comp_violation_irq_en,
   input wire logic [15:0]    secondary_sample_point,
   input wire logic           delay_comp_violation,
   input wire logic           channel_error_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire act0 = dma_status_reg.rxfifo_dma_active[0];

   chk_rx_req_level: assert property (
      rx_dma_req == $past(rx_dma_enable_reg & rx_unread)) else $error("rx request wrong");
   chk_rx_req_drop: assert property (
      !(rx_unread[0] && rx_dma_enable_reg[0]) |=> !rx_dma_req[0]) else $error("rx request kept");
   chk_store_kept: assert property (
      rx_store_strobe == $past(rx_msg_arrive & rx_fifo_on)) else $error("store strobe wrong");
   chk_tx_req_level: assert property (
      tx_dma_req == $past(tx_dma_enable_reg & tx_space)) else $error("tx request wrong");
   chk_active_hold: assert property (
      rx_dma_ack[0] || act0 && !rx_dma_done[0] |=> act0) else $error("active lost");
   chk_active_clear: assert property (
      rx_dma_done[0] && !rx_dma_ack[0] |=> !act0) else $error("active stuck");
   chk_irq_follow: assert property (
      channel_error_irq == (delay_comp_violation && $past(delay_comp_violation_irq_en)))
      else $error("irq wrong");
   chk_ssp_idle: assert property (
      $past(!fd_config_reg.delay_comp_enable) |-> secondary_sample_point == 16'h0000)
      else $error("ssp while off");
   chk_viol_sticky: assert property (
      delay_comp_violation && !violation_clear |=> delay_comp_violation) else $error("flag lost");
   chk_txq_single: assert property (
      tx_ptr_advance[1] |=> !tx_ptr_advance[1] [*8]) else $error("txq advance early");

   cov_rx_req: cover property (rx_dma_req[0] ##1 act0);
   cov_tx_adv: cover property (tx_ptr_advance[2]);
   cov_viol: cover property ($rose(channel_error_irq));
endmodule // canfd_dma_tdc_mode_timing_asserts

bind canfd_dma_tdc_mode_timing canfd_dma_tdc_mode_timing_asserts
   i_canfd_dma_tdc_mode_timing_asserts (.*);
`default_nettype wire

// *** sim/dma_partner.sv ***
// dma controller model: rx source 0 and the three tx targets
// assumes request levels; acts 5 ns after the clock edge
`timescale 1ns/1ns
`default_nettype none
module dma_partner
   import canfd_dma_tdc_pkg::*;
(
   // from the block
   input  wire logic       core_clk,
   input  wire logic [8:0] rx_dma_req,
   input  wire logic [2:0] tx_dma_req,
   input  wire logic [2:0] trxfifo_payload_size,
   // to the block
   output logic [8:0]      rx_dma_ack,
   output logic [8:0]      rx_dma_done,
   output logic [2:0]      tx_word_wr,
   output logic [2:0]      tx_dma_done
);
   int words [8] = '{2, 3, 4, 5, 6, 8, 12, 16};
   int k;
   task tick();
      @(posedge core_clk);
      #5;
   endtask
   initial begin
      {rx_dma_ack, rx_dma_done, tx_word_wr, tx_dma_done} = '0;
      forever begin
         tick();
         if (rx_dma_req[0]) begin
            // one request reads the whole payload; slow on purpose
            rx_dma_ack[0] = 1'b1;
            tick();
            rx_dma_ack[0] = 1'b0;
            repeat (6) tick();
            rx_dma_done[0] = 1'b1;
            tick();
            rx_dma_done[0] = 1'b0;
         end else if (|tx_dma_req) begin
            k = tx_dma_req[0] ? 0 : (tx_dma_req[1] ? 1 : 2);
            // queues always take 64 bytes, short payloads padded
            repeat (k == 0 ? words[trxfifo_payload_size] : 16) begin
               tx_word_wr[k] = 1'b1;
               tick();
            end
            tx_word_wr[k] = 1'b0;
            tx_dma_done[k] = 1'b1;
            tick();
            tx_dma_done[k] = 1'b0;
            while (tx_dma_req[k]) tick();
         end
      end
   end
endmodule // dma_partner
`default_nettype wire

// *** sim/test_canfd_dma_tdc_mode_timing.sv ***
// testbench: dma triggers, delay compensation and mode timing
// assumes dma_partner and the bound checker beside the block
`timescale 1ns/1ns
`default_nettype none
module test_canfd_dma_tdc_mode_timing;
   import canfd_dma_tdc_pkg::*;
   logic core_clk, rst, fdf_res_edge, can_rx, violation_clear, delay_comp_violation_irq_en;
   logic frame_end, bus_idle, global_req_valid, channel_req_valid, global_busy, channel_busy;
   logic delay_comp_violation, channel_error_irq;
   rx_dma_enable_s rx_dma_enable_reg;
   tx_dma_enable_s tx_dma_enable_reg;
   fd_config_s fd_config_reg;
   dma_status_s dma_status_reg;
   logic [8:0] rx_unread, rx_dma_ack, rx_dma_done, rx_dma_req, rx_fifo_on, rx_msg_arrive;
   logic [8:0] rx_store_strobe;
   logic [2:0] trxfifo_payload_size, tx_space, tx_word_wr, tx_dma_done, tx_dma_req;
   logic [2:0] tx_ptr_advance, last;
   logic [7:0] data_prescaler, delay_comp_result;
   logic [11:0] data_bit_clocks;
   logic [15:0] nominal_bit_clocks, secondary_sample_point;
   mode_e global_mode_req, channel_mode_req, global_mode, channel_mode;
   int errors, n_checks, adv, a;

   canfd_dma_tdc_mode_timing i_canfd_dma_tdc_mode_timing (.*);
   dma_partner i_dma_partner (.*);

   // ------------------------------
   // tasks
   // ------------------------------
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #5;
   endtask
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // e is the mode expected once lim cycles have passed
   task mgo(input bit g, input mode_e m, input mode_e e, input int lim);
      if (g) {global_mode_req, global_req_valid} = {m, 1'b1};
      else {channel_mode_req, channel_req_valid} = {m, 1'b1};
      step(1);
      {global_req_valid, channel_req_valid} = 2'b00;
      repeat (lim) if ((g ? global_mode : channel_mode) != m) step(1);
      cmp({g ? global_busy : channel_busy, g ? global_mode : channel_mode}, e);
   endtask
   task meas(input int d);
      fdf_res_edge = 1'b1;
      step(1);
      fdf_res_edge = 1'b0;
      step(d);
      can_rx = 1'b0;
      step(d + 8);
      can_rx = 1'b1;
      step(2);
   endtask
   task close_out();
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge core_clk) adv <= adv + $countones(tx_ptr_advance);
   always @(posedge core_clk) if (|tx_ptr_advance) last <= tx_ptr_advance;
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #500000;
      errors++;
      close_out();
   end

   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      {rst, can_rx, bus_idle, data_bit_clocks, nominal_bit_clocks} = {3'b111, 12'h014, 16'h0004};
      {rx_dma_enable_reg, rx_unread, rx_fifo_on, rx_msg_arrive, tx_dma_enable_reg} = '0;
      {tx_space, fd_config_reg, data_prescaler, fdf_res_edge, violation_clear} = '0;
      {delay_comp_violation_irq_en, trxfifo_payload_size, frame_end} = '0;
      {global_req_valid, channel_req_valid, errors, n_checks, adv} = '0;
      {global_mode_req, channel_mode_req} = {MODE_STOP, MODE_STOP};
      step(3);
      rst = 1'b0;
      cmp({global_mode, channel_mode}, 16'h000f);
      mgo(1, MODE_RESET, MODE_RESET, 3);
      mgo(1, MODE_HOLD, MODE_HOLD, 10);
      mgo(1, MODE_RUN, MODE_RUN, 3);
      mgo(1, MODE_HOLD, MODE_HOLD, 3);
      mgo(1, MODE_RESET, MODE_RESET, 10);
      mgo(0, MODE_RUN, MODE_STOP, 10);
      mgo(0, MODE_RESET, MODE_RESET, 3);
      mgo(0, MODE_HOLD, MODE_HOLD, 14);
      mgo(0, MODE_RUN, MODE_RUN, 18);
      mgo(0, MODE_HOLD, MODE_HOLD, 2);
      {rx_dma_enable_reg, rx_unread} = {9'h001, 9'h001};
      step(2);
      cmp(rx_dma_req, 16'h0001);
      repeat (10) if (!dma_status_reg.rxfifo_dma_active[0]) step(1);
      rx_dma_enable_reg = 9'h000;
      step(2);
      cmp(rx_dma_req, 16'h0000);
      cmp(dma_status_reg.rxfifo_dma_active[0], 16'h0001);
      repeat (12) if (dma_status_reg.rxfifo_dma_active[0]) step(1);
      cmp(dma_status_reg.rxfifo_dma_active[0], 16'h0000);
      {rx_unread, rx_fifo_on, rx_msg_arrive} = {9'h000, 9'h008, 9'h008};
      step(1);
      rx_msg_arrive = 9'h000;
      cmp(rx_store_strobe, 16'h0008);
      for (int s = 0; s < 10; s++) begin
         {trxfifo_payload_size, a} = {s[2:0], adv};
         {tx_dma_enable_reg, tx_space} = {3'h1 << (s / 8 * (s - 7)), 3'h1 << (s / 8 * (s - 7))};
         step(1);
         cmp(tx_dma_req, tx_space);
         repeat (40) if (adv == a) step(1);
         {tx_dma_enable_reg, tx_space} = 6'h00;
         step(4);
         cmp(adv - a, 16'h0001);
         cmp(last, 3'h1 << (s / 8 * (s - 7)));
      end
      fd_config_reg = {2'b10, 8'h0a};
      meas(7);
      cmp(delay_comp_result, 16'h0007);
      cmp(secondary_sample_point, 16'h0011);
      fd_config_reg = {2'b11, 8'h1f};
      meas(3);
      cmp(secondary_sample_point, 16'h0020);
      cmp(delay_comp_result, 16'h0007);
      {fd_config_reg, data_bit_clocks} = {2'b10, 8'h0a, 12'h002};
      meas(10);
      cmp(delay_comp_violation, 16'h0000);
      meas(20);
      cmp({delay_comp_violation, channel_error_irq}, 16'h0002);
      delay_comp_violation_irq_en = 1'b1;
      step(1);
      cmp(channel_error_irq, 16'h0001);
      violation_clear = 1'b1;
      step(1);
      {violation_clear, fd_config_reg} = '0;
      step(2);
      cmp({delay_comp_violation, secondary_sample_point}, 16'h0000);
      close_out();
   end
endmodule // test_canfd_dma_tdc_mode_timing
`default_nettype wire
